// ### design/faee_defines.vh
/*
 * constants for the flash array ecc engine: unit geometry, code widths,
 * status field positions and reset values.
 * assumes inclusion by bare name from the design file.
 */
`ifndef FAEE_DEFINES_VH
`define FAEE_DEFINES_VH

// ****************************************************************
// data unit geometry
// ****************************************************************
`define FAEE_UNIT_BYTES     16
`define FAEE_UNIT_BITS      128
`define FAEE_UNIT_LSB       4
`define FAEE_SEC_CODE_W     8
`define FAEE_CODE_W         9
`define FAEE_ERASED_BYTE    8'hff

// ****************************************************************
// per-unit status byte fields
// ****************************************************************
`define FAEE_US_OFF_BIT     0
`define FAEE_US_C1_BIT      1
`define FAEE_US_D2_BIT      3

// ****************************************************************
// sticky error status fields
// ****************************************************************
`define FAEE_ST_C1_BIT      3
`define FAEE_ST_D2_BIT      4

// ****************************************************************
// reset values
// ****************************************************************
`define FAEE_STATUS_RST     8'h00
`define FAEE_TRAP_RST       32'h0000_0000
`define FAEE_CNT_RST        16'h0000

`endif

// ### design/faee_engine.v
/*
 * flash array ecc engine: hamming code generation on program, check and
 * correction on read, per-unit flags, sticky status, address trap, error
 * counter and alert output.
 * assumes the array controller presents one whole 16-byte unit per strobe,
 * stores the check code beside it, and returns it with the unit on read.
 */
// How it works
// - code is computed and checked over aligned 16-byte data units.
// - each programmed unit gets a check code stored in hidden array space.
// - every array read of a unit with checking on checks it and fixes a single-bit error.
// - first program of an erased unit codes the whole unit, unwritten bytes erased.
// - single-bit mode, reprogramming a unit turns checking off and sets its flag.
// - checking on a disabled unit returns only after its sector is erased or on reset.
// - default double-detect mode corrects one-bit errors and reports two-bit errors.
// - double-detect mode uses a 9-bit code instead of 8 bits.
// - double-detect mode refuses any repeated unit program and flags a program error.
// - mode change leaves old programmed data undefined on read.
// - per-unit status tells corrected one-bit or detected two-bit error.
// - sticky status records any one- or two-bit error since clear or reset.
// - trap latches the first failing read address, held until the clear command or reset.
// - counter increments for each unit read with a one- or two-bit error.
// - alert output, when enabled, fires on each detected read error.
// - mode bit one selects double-detect; zero forces two-bit flag to zero.
// - sticky status clears on reset and on the clear command.
// - trap updates only on array reads, first failing unit since clear or reset only.
`default_nettype none

`include "faee_defines.vh"

module faee_engine #(
    parameter NUM_UNITS        = 64,
    parameter UNITS_PER_SECTOR = 16,
    parameter CNT_W            = 16
) (
    input  wire                   clk_sys_i,
    input  wire                   arst_n_i,
    input  wire                   mode_select_bit_i,
    input  wire                   alert_en_i,
    input  wire                   clr_status_i,
    input  wire                   prog_req_i,
    input  wire [31:0]            prog_addr_i,
    input  wire [127:0]           prog_data_i,
    input  wire [15:0]            prog_be_i,
    output reg                    prog_valid_o,
    output reg                    prog_err_o,
    output reg  [127:0]           prog_data_o,
    output reg  [8:0]             prog_code_o,
    input  wire                   erase_req_i,
    input  wire [31:0]            erase_addr_i,
    input  wire                   rd_req_i,
    input  wire [31:0]            rd_addr_i,
    input  wire [127:0]           rd_data_i,
    input  wire [8:0]             rd_code_i,
    output reg                    rd_valid_o,
    output reg  [127:0]           rd_data_o,
    input  wire [31:0]            stat_addr_i,
    output wire [7:0]             unit_status_o,
    output reg  [7:0]             sticky_error_status_o,
    output reg  [31:0]            failing_address_trap_o,
    output reg  [CNT_W-1:0]       err_count_o,
    output reg                    alert_o
);

    localparam UNIT_W = (NUM_UNITS > 1) ? $clog2(NUM_UNITS) : 1;
    localparam SECT_W = (UNITS_PER_SECTOR > 1) ? $clog2(UNITS_PER_SECTOR) : 1;

    // ****************************************************************
    // reset release
    // ****************************************************************
    reg rst_meta_q;
    reg rst_n_q;

    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************************************
    // hamming code: data bits at non-power-of-two positions
    // ****************************************************************
    function [8:0] calc_code;
        input [127:0] data;
        integer i;
        reg [8:0] p;
        reg [7:0] syn;
        begin
            p   = 9'h003;
            syn = 8'h00;
            for (i = 0; i < `FAEE_UNIT_BITS; i = i + 1) begin
                if (data[i])
                    syn = syn ^ p[7:0];
                p = p + 9'h001;
                if ((p & (p - 9'h001)) == 9'h000)
                    p = p + 9'h001;
            end
            calc_code = {(^data) ^ (^syn), syn};
        end
    endfunction

    wire ded_mode = mode_select_bit_i;

    // ****************************************************************
    // per-unit flags
    // ****************************************************************
    reg  [NUM_UNITS-1:0] prog_done_q;
    reg  [NUM_UNITS-1:0] off_q;
    reg  [NUM_UNITS-1:0] u_c1_q;
    reg  [NUM_UNITS-1:0] u_d2_q;

    wire [UNIT_W-1:0] prog_unit = prog_addr_i[`FAEE_UNIT_LSB +: UNIT_W];
    wire [UNIT_W-1:0] rd_unit   = rd_addr_i[`FAEE_UNIT_LSB +: UNIT_W];
    wire [UNIT_W-1:0] st_unit   = stat_addr_i[`FAEE_UNIT_LSB +: UNIT_W];
    wire [UNIT_W-1:0] er_unit   = erase_addr_i[`FAEE_UNIT_LSB +: UNIT_W];
    wire [UNIT_W-1:0] er_sect   = er_unit >> SECT_W;

    wire reprog     = prog_req_i && prog_done_q[prog_unit];
    wire prog_rej   = reprog && ded_mode;
    wire prog_acc   = prog_req_i && !prog_rej;
    wire rd_checked = rd_req_i && !off_q[rd_unit];

    // ****************************************************************
    // read check and correction
    // ****************************************************************
    reg  [127:0] fixed_data;
    reg  [8:0]   p_idx;
    integer      j;

    wire [8:0] rd_calc  = calc_code(rd_data_i);
    wire [7:0] syndrome = rd_calc[7:0] ^ rd_code_i[7:0];
    wire       par_err  = (^rd_data_i) ^ (^rd_code_i);
    wire       raw_c1   = ded_mode ? par_err : (syndrome != 8'h00);
    wire       raw_d2   = ded_mode && !par_err && (syndrome != 8'h00);
    wire       ev_c1    = rd_checked && raw_c1;
    wire       ev_d2    = rd_checked && raw_d2;
    wire       ev_err   = ev_c1 || ev_d2;

    always @* begin
        fixed_data = rd_data_i;
        p_idx      = 9'h003;
        for (j = 0; j < `FAEE_UNIT_BITS; j = j + 1) begin
            if (rd_checked && raw_c1 && syndrome == p_idx[7:0])
                fixed_data[j] = ~rd_data_i[j];
            p_idx = p_idx + 9'h001;
            if ((p_idx & (p_idx - 9'h001)) == 9'h000)
                p_idx = p_idx + 9'h001;
        end
    end

    // ****************************************************************
    // program path: merge unwritten bytes as erased, then code
    // ****************************************************************
    reg  [127:0] merged;
    integer      b;

    always @* begin
        merged = prog_data_i;
        for (b = 0; b < `FAEE_UNIT_BYTES; b = b + 1) begin
            if (!prog_be_i[b])
                merged[b*8 +: 8] = `FAEE_ERASED_BYTE;
        end
    end

    wire [8:0] prog_calc = calc_code(merged);

    always @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prog_valid_o <= 1'b0;
            prog_err_o   <= 1'b0;
            prog_data_o  <= 128'h0;
            prog_code_o  <= 9'h000;
        end else begin
            prog_valid_o <= prog_acc;
            prog_err_o   <= prog_rej;
            if (prog_acc) begin
                prog_data_o <= merged;
                prog_code_o <= {ded_mode & prog_calc[8], prog_calc[7:0]};
            end
        end
    end

    // ****************************************************************
    // per-unit flag update, one generate lane per unit
    // ****************************************************************
    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u = u + 1) begin : g_unit
            wire sect_hit = erase_req_i && ((u / UNITS_PER_SECTOR) == er_sect);
            always @(posedge clk_sys_i or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    prog_done_q[u] <= 1'b0;
                    off_q[u]       <= 1'b0;
                    u_c1_q[u]      <= 1'b0;
                    u_d2_q[u]      <= 1'b0;
                end else if (sect_hit) begin
                    prog_done_q[u] <= 1'b0;
                    off_q[u]       <= 1'b0;
                    u_c1_q[u]      <= 1'b0;
                    u_d2_q[u]      <= 1'b0;
                end else begin
                    if (prog_acc && prog_unit == u) begin
                        prog_done_q[u] <= 1'b1;
                        if (reprog)
                            off_q[u] <= 1'b1;
                    end
                    if (rd_req_i && rd_unit == u) begin
                        u_c1_q[u] <= ev_c1;
                        u_d2_q[u] <= ev_d2;
                    end
                end
            end
        end
    endgenerate

    assign unit_status_o = {4'h0,
                            ded_mode & u_d2_q[st_unit],
                            1'b0,
                            u_c1_q[st_unit],
                            off_q[st_unit]};

    // ****************************************************************
    // read output, sticky status, trap, counter, alert
    // ****************************************************************
    reg trap_full_q;

    always @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_valid_o             <= 1'b0;
            rd_data_o              <= 128'h0;
            sticky_error_status_o  <= `FAEE_STATUS_RST;
            failing_address_trap_o <= `FAEE_TRAP_RST;
            trap_full_q            <= 1'b0;
            err_count_o            <= `FAEE_CNT_RST;
            alert_o                <= 1'b0;
        end else begin
            rd_valid_o <= rd_req_i;
            if (rd_req_i)
                rd_data_o <= fixed_data;
            if (clr_status_i)
                sticky_error_status_o <= `FAEE_STATUS_RST;
            if (ev_c1)
                sticky_error_status_o[`FAEE_ST_C1_BIT] <= 1'b1;
            if (ev_d2)
                sticky_error_status_o[`FAEE_ST_D2_BIT] <= 1'b1;
            if (clr_status_i)
                trap_full_q <= 1'b0;
            if (ev_err && !trap_full_q) begin
                failing_address_trap_o <= rd_addr_i;
                trap_full_q            <= 1'b1;
            end
            if (ev_err)
                err_count_o <= err_count_o + {{(CNT_W-1){1'b0}}, 1'b1};
            alert_o <= alert_en_i && ev_err;
        end
    end

endmodule

`default_nettype wire

// ### dv/faee_array_model.sv
/* array model: keeps each programmed unit with its code, returns it on reads
   with a flip mask applied. assumes one whole unit per program strobe. */
`default_nettype none
module faee_array_model (
    input  wire logic         clk_sys_i,
    input  wire logic         prog_req_i,
    input  wire logic [31:0]  prog_addr_i,
    input  wire logic         prog_valid_i,
    input  wire logic [136:0] prog_unit_i,
    input  wire logic         rd_req_i,
    input  wire logic [31:0]  rd_addr_i,
    input  wire logic [127:0] flip_i,
    output logic      [136:0] rd_unit_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [136:0] mem_q [64];
    logic [5:0]   wu_q;
    logic         tog_q = 1'b0;
    always @(posedge clk_sys_i) begin
        tog_q <= ~tog_q;
        if (prog_req_i) wu_q <= prog_addr_i[9:4];
        if (prog_valid_i) mem_q[wu_q] <= prog_unit_i;
    end
    // idle lines toggle so a stale unit cannot pass
    assign rd_unit_o = rd_req_i ? mem_q[rd_addr_i[9:4]] ^ {9'h0, flip_i} : {137{tog_q}};
endmodule
`default_nettype wire

// ### dv/faee_engine_assertions.sv
/* checker for answers, counter, trap, sticky status and alert.
   assumes it is bound to faee_engine. */
`default_nettype none
module faee_engine_assertions #(
    parameter CNT_W = 16
) (
    input wire logic             clk_sys_i,
    input wire logic             arst_n_i,
    input wire logic             mode_select_bit_i,
    input wire logic             alert_en_i,
    input wire logic             clr_status_i,
    input wire logic             prog_req_i,
    input wire logic             rd_req_i,
    input wire logic             prog_valid_o,
    input wire logic             prog_err_o,
    input wire logic             rd_valid_o,
    input wire logic [7:0]       unit_status_o,
    input wire logic [7:0]       sticky_error_status_o,
    input wire logic [31:0]      failing_address_trap_o,
    input wire logic [CNT_W-1:0] err_count_o,
    input wire logic             alert_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_fail;
        rd_valid_o && $changed(err_count_o);
    endsequence
    AST_RD: assert property (rd_req_i |=> rd_valid_o) else $error("no read answer");
    AST_PROG: assert property (prog_req_i |=> prog_valid_o != prog_err_o)
        else $error("program answer wrong");
    AST_CNT: assert property ($changed(err_count_o) |->
        rd_valid_o && err_count_o == $past(err_count_o) + 1'b1) else $error("count step");
    AST_ALERT: assert property ($past(alert_en_i) ##0 s_fail |-> alert_o)
        else $error("alert missing");
    AST_TRAP: assert property ($changed(failing_address_trap_o) |-> rd_valid_o &&
        ($past(sticky_error_status_o[4:3]) == 2'b00 || $past(clr_status_i)))
        else $error("trap moved");
    AST_CLR: assert property (clr_status_i && !rd_req_i |=> sticky_error_status_o == 8'h00)
        else $error("sticky not cleared");
    AST_STICKY: assert property ($fell(sticky_error_status_o[3]) |-> $past(clr_status_i))
        else $error("sticky lost");
    AST_MODE0: assert property (!mode_select_bit_i |-> !unit_status_o[3])
        else $error("two-bit flag in single-bit mode");
endmodule
bind faee_engine faee_engine_assertions #(.CNT_W(CNT_W)) chk (
    .clk_sys_i, .arst_n_i, .mode_select_bit_i, .alert_en_i, .clr_status_i, .prog_req_i,
    .rd_req_i, .prog_valid_o, .prog_err_o, .rd_valid_o, .unit_status_o,
    .sticky_error_status_o, .failing_address_trap_o, .err_count_o, .alert_o);
`default_nettype wire

// ### dv/faee_engine_tb_top.sv
/* bench: programs units, reads them back through the array model with
   flipped bits, checks status. assumes engine and model are compiled. */
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module faee_engine_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, mode_select_bit_i = 1'b1, alert_en_i = 1'b1;
    logic clr_status_i = 1'b0, prog_req_i = 1'b0, erase_req_i = 1'b0, rd_req_i = 1'b0;
    logic [31:0] prog_addr_i = '0, erase_addr_i = '0, rd_addr_i = '0, stat_addr_i = '0;
    logic [15:0] prog_be_i = '0;
    logic [127:0] prog_data_i = '0, flip = '0;
    wire [127:0] rd_data_i, prog_data_o, rd_data_o;
    wire [8:0] rd_code_i, prog_code_o;
    wire [7:0] unit_status_o, sticky_error_status_o;
    wire [31:0] failing_address_trap_o;
    wire [15:0] err_count_o;
    wire prog_valid_o, prog_err_o, rd_valid_o, alert_o;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    localparam logic [127:0] D = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    localparam logic [127:0] M = {64'hffff_ffff_ffff_ffff, D[63:0]};
    always #5 clk_sys_i = ~clk_sys_i;
    faee_engine uut (.clk_sys_i, .arst_n_i, .mode_select_bit_i, .alert_en_i, .clr_status_i,
        .prog_req_i, .prog_addr_i, .prog_data_i, .prog_be_i, .prog_valid_o, .prog_err_o,
        .prog_data_o, .prog_code_o, .erase_req_i, .erase_addr_i, .rd_req_i, .rd_addr_i,
        .rd_data_i, .rd_code_i, .rd_valid_o, .rd_data_o, .stat_addr_i, .unit_status_o,
        .sticky_error_status_o, .failing_address_trap_o, .err_count_o, .alert_o);
    faee_array_model array (.clk_sys_i, .prog_req_i, .prog_addr_i, .prog_valid_i(prog_valid_o),
        .prog_unit_i({prog_code_o, prog_data_o}), .rd_req_i, .rd_addr_i, .flip_i(flip),
        .rd_unit_o({rd_code_i, rd_data_i}));
    // k: program, read, erase strobes; d is data or read flip mask
    task automatic op(input logic [2:0] k, input logic [31:0] a, input logic [127:0] d,
                      input logic [15:0] b = 16'hffff);
        @(posedge clk_sys_i);
        {prog_req_i, rd_req_i, erase_req_i} <= k;
        {prog_addr_i, rd_addr_i, erase_addr_i, stat_addr_i} <= {4{a}};
        {prog_data_i, flip, prog_be_i} <= {d, d, b};
        @(posedge clk_sys_i);
        {prog_req_i, rd_req_i, erase_req_i} <= 3'h0;
        #1;
    endtask
    task automatic t_good();
        op(3'h4, 32'h10, D, 16'h00ff);
        `CHK("merged", M, prog_data_o)
        `CHK("prog_valid", 1'b1, prog_valid_o)
        op(3'h2, 32'h10, 128'h0);
        `CHK("data", M, rd_data_o)
        `CHK("rd_valid", 1'b1, rd_valid_o)
        `CHK("ustat", 8'h00, unit_status_o)
        `CHK("count", 16'h0000, err_count_o)
        op(3'h4, 32'h1c, D, 16'h0100);
        `CHK("prog_err", 1'b1, prog_err_o)
        `CHK("prog_valid", 1'b0, prog_valid_o)
        $display("t_good done");
    endtask
    task automatic t_err();
        op(3'h2, 32'h14, 128'h20);
        `CHK("data", M, rd_data_o)
        `CHK("ustat", 8'h02, unit_status_o)
        `CHK("trap", 32'h14, failing_address_trap_o)
        `CHK("alert", 1'b1, alert_o)
        op(3'h2, 32'h18, 128'h3 << 70);
        `CHK("ustat", 8'h08, unit_status_o)
        `CHK("sticky", 8'h18, sticky_error_status_o)
        `CHK("count", 16'h0002, err_count_o)
        `CHK("trap", 32'h14, failing_address_trap_o)
        $display("t_err done");
    endtask
    task automatic t_clr();
        @(posedge clk_sys_i);
        {clr_status_i, alert_en_i} <= 2'b10;
        @(posedge clk_sys_i);
        clr_status_i <= 1'b0;
        op(3'h2, 32'h1c, 128'h1);
        `CHK("trap", 32'h1c, failing_address_trap_o)
        `CHK("alert", 1'b0, alert_o)
        `CHK("sticky", 8'h08, sticky_error_status_o)
        $display("t_clr done");
    endtask
    task automatic t_mode0();
        for (int s = 0; s < 4; s++) op(3'h1, s << 8, 128'h0);
        @(posedge clk_sys_i);
        {mode_select_bit_i, alert_en_i} <= 2'b01;
        op(3'h4, 32'h20, D);
        `CHK("code8", 1'b0, prog_code_o[8])
        op(3'h4, 32'h24, D, 16'h0001);
        op(3'h2, 32'h20, 128'h3);
        `CHK("raw", {{15{8'hff}}, D[7:0]} ^ 128'h3, rd_data_o)
        `CHK("ustat", 8'h01, unit_status_o)
        op(3'h1, 32'h20, 128'h0);
        `CHK("ustat", 8'h00, unit_status_o)
        op(3'h4, 32'h20, D);
        op(3'h2, 32'h20, 128'h3);
        `CHK("ustat", 8'h02, unit_status_o)
        `CHK("count", 16'h0004, err_count_o)
        `CHK("alert", 1'b1, alert_o)
        $display("t_mode0 done");
    endtask
    task automatic t_rst();
        @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        `CHK("count", 16'h0000, err_count_o)
        `CHK("sticky", 8'h00, sticky_error_status_o)
        `CHK("trap", 32'h0000_0000, failing_address_trap_o)
        @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        op(3'h2, 32'h24, 128'h4);
        `CHK("data", D, rd_data_o)
        `CHK("trap", 32'h24, failing_address_trap_o)
        `CHK("sticky", 8'h08, sticky_error_status_o)
        `CHK("count", 16'h0001, err_count_o)
        $display("t_rst done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        t_good();
        t_err();
        t_clr();
        t_mode0();
        t_rst();
        summarize();
    end
endmodule
`default_nettype wire
